// ### ttsc_cfg.svh
// offsets, field positions, reset values and codes of the trip block
`ifndef TTSC_CFG_SVH
`define TTSC_CFG_SVH

`define TTSC_ADDR_W          9
`define TTSC_DATA_W          32

`define TTSC_OFS_TRIP        9'h0e4
`define TTSC_OFS_CAP         9'h0e8
`define TTSC_OFS_IRQ_STAT    9'h100
`define TTSC_OFS_IRQ_MASK    9'h104
`define TTSC_OFS_EVCNT       9'h108

`define TTSC_TRIP_SW_BIT     31
`define TTSC_TRIP_DIODE_MSB  14
`define TTSC_TRIP_DIODE_LSB  8
`define TTSC_TRIP_SUP_BIT    5
`define TTSC_TRIP_SENSE_BIT  3
`define TTSC_TRIP_STATE_BIT  1

`define TTSC_CAP_CORE_MSB    13
`define TTSC_CAP_CORE_LSB    12
`define TTSC_CAP_RETRY_BIT   11
`define TTSC_CAP_THERM_BIT   10
`define TTSC_CAP_VIRT_BIT    9
`define TTSC_CAP_MEMCTL_BIT  8
`define TTSC_CAP_RATE_MSB    7
`define TTSC_CAP_RATE_LSB    5
`define TTSC_CAP_DUAL_BIT    0

`define TTSC_CORES_ONE       2'h0
`define TTSC_CORES_TWO       2'h1
`define TTSC_RATE_NO_LIMIT   3'h0
`define TTSC_RATE_1067       3'h3
`define TTSC_RATE_400        3'h7

`define TTSC_RST_WORD        32'h0000_0000
`define TTSC_DIODE_DFLT      7'h0b

`define TTSC_IRQ_W           2
`define TTSC_IRQ_OVERTEMP    0
`define TTSC_IRQ_TRIP        1
`define TTSC_IRQ_RST         2'h0

`endif

// ### ttsc_pkg.sv
// types shared by the trip status block
package ttsc_pkg;

  typedef enum logic [2:0] {
    sel_none      = 3'b000,
    sel_trip      = 3'b001,
    sel_cap       = 3'b010,
    sel_irq_stat  = 3'b011,
    sel_irq_mask  = 3'b100,
    sel_evcnt     = 3'b101
  } ttsc_sel_type;

  typedef logic [31:0] ttsc_word_type;

endpackage

// ### ttsc_reg_if.sv
// register access path between bus slave and register bank
`timescale 1ns/10ps
`include "ttsc_cfg.svh"

interface ttsc_reg_if;
  logic                     wr;
  logic                     rd;
  logic [`TTSC_ADDR_W-1:0]  addr;
  logic [`TTSC_DATA_W-1:0]  wdata;
  logic [3:0]               be;
  logic [`TTSC_DATA_W-1:0]  rdata;

  modport bus (
    output wr,
    output rd,
    output addr,
    output wdata,
    output be,
    input  rdata
  );

  modport regs (
    input  wr,
    input  rd,
    input  addr,
    input  wdata,
    input  be,
    output rdata
  );
endinterface // ttsc_reg_if

// ### ttsc_sync3.sv
// three-stage synchroniser for an asynchronous level input
`timescale 1ns/10ps

module ttsc_sync3 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      level_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // only a change seen by two stages counts
      if (s2_ff == s3_ff) begin
        level_o <= s3_ff;
      end
    end
  end
endmodule // ttsc_sync3

// ### ttsc_wb_slave.sv
// classic wishbone slave front end of the trip register bank
`timescale 1ns/10ps
`include "ttsc_cfg.svh"

module ttsc_wb_slave (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [`TTSC_ADDR_W-1:0] adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [`TTSC_DATA_W-1:0] dat_i,
  output logic      [`TTSC_DATA_W-1:0] dat_o,
  output logic                         ack_o,
  ttsc_reg_if.bus                      rif
);
  logic ack_ff;
  wire  req;

  // one access per request, ack drops the cycle after
  assign req       = cyc_i & stb_i & ~ack_ff;
  assign rif.wr    = req & we_i;
  assign rif.rd    = req & ~we_i;
  assign rif.addr  = adr_i;
  assign rif.wdata = dat_i;
  assign rif.be    = sel_i;
  assign dat_o     = rif.rdata;
  assign ack_o     = ack_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end
endmodule // ttsc_wb_slave

// ### ttsc_top.sv
// thermal trip status and capabilities register bank
`timescale 1ns/10ps
`include "ttsc_cfg.svh"

module ttsc_top
  import ttsc_pkg::*;
#(
  parameter logic [6:0] DIODE_CORRECTION    = `TTSC_DIODE_DFLT,
  parameter logic       TRIP_STATE_SUPPORT  = 1'b1,
  parameter logic [1:0] CORE_COUNT_CODE     = `TTSC_CORES_TWO,
  parameter logic [2:0] DRAM_RATE_CODE      = `TTSC_RATE_NO_LIMIT,
  parameter logic       DUAL_CHANNEL        = 1'b1,
  parameter logic       MEMCTL_PRESENT      = 1'b1,
  parameter logic       THERMAL_CONTROL     = 1'b1,
  parameter logic       VIRTUALIZATION      = 1'b1,
  parameter logic       LINK_RETRY          = 1'b1,
  parameter int         EVCNT_W             = 8
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    warm_rst_i,
  input  wire logic                    overtemp_pin_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`TTSC_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [`TTSC_DATA_W-1:0] wb_dat_i,
  output logic      [`TTSC_DATA_W-1:0] wb_dat_o,
  output logic                         wb_ack_o,
  output logic                         trip_event_o,
  output logic                         trip_state_o,
  output logic                         irq_o
);

  // reserved core codes are reported as one core
  function automatic logic [1:0] core_code_legal(
    input logic [1:0] code
  );
    logic [1:0] res;
    res = code;
    if (code != `TTSC_CORES_ONE && code != `TTSC_CORES_TWO) begin
      res = `TTSC_CORES_ONE;
    end
    return res;
  endfunction

  // rate codes 1 and 2 fall back to no limit; codes 4 to 6 pass unchanged
  function automatic logic [2:0] rate_code_legal(
    input logic [2:0] code
  );
    logic [2:0] res;
    res = code;
    if (code != `TTSC_RATE_NO_LIMIT && code < `TTSC_RATE_1067) begin
      res = `TTSC_RATE_NO_LIMIT;
    end
    return res;
  endfunction

  ttsc_reg_if rif ();

  logic                     overtemp_lvl;
  logic                     overtemp_lvl_d_ff;
  logic                     overtemp_sensed_ff;
  logic                     nxt_overtemp_sensed;
  logic                     trip_state_ff;
  logic                     nxt_trip_state;
  logic                     trip_event_ff;
  logic [`TTSC_IRQ_W-1:0]   irq_stat_ff;
  wire  [`TTSC_IRQ_W-1:0]   nxt_irq_stat;
  logic [`TTSC_IRQ_W-1:0]   irq_mask_ff;
  logic [`TTSC_IRQ_W-1:0]   nxt_irq_mask;
  logic [EVCNT_W-1:0]       evcnt_ff;
  logic [EVCNT_W-1:0]       nxt_evcnt;
  logic [`TTSC_DATA_W-1:0]  rdata_ff;
  logic                     irq_ff;

  ttsc_sel_type             sel;
  ttsc_word_type            trip_word;
  ttsc_word_type            cap_word;
  ttsc_word_type            read_word;

  wire [6:0] word_idx;
  wire       hit_trip;
  wire       hit_cap;
  wire       hit_irq_stat;
  wire       hit_irq_mask;
  wire       hit_evcnt;
  wire       soft_trip_trigger;
  wire       overtemp_rise;
  wire       trip_event;
  wire       enter_trip;
  wire       stat_clr_wr;
  wire       mask_wr;
  wire [`TTSC_IRQ_W-1:0] irq_set;
  wire [`TTSC_IRQ_W-1:0] irq_clr;
  wire       evcnt_full;
  wire [`TTSC_IRQ_W-1:0] irq_pend;
  wire [1:0] core_field;
  wire [2:0] rate_field;

  ttsc_wb_slave u_wb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (wb_cyc_i),
    .stb_i (wb_stb_i),
    .we_i  (wb_we_i),
    .adr_i (wb_adr_i),
    .sel_i (wb_sel_i),
    .dat_i (wb_dat_i),
    .dat_o (wb_dat_o),
    .ack_o (wb_ack_o),
    .rif   (rif.bus)
  );

  // pin is asynchronous to clk_i
  ttsc_sync3 u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (overtemp_pin_i),
    .level_o (overtemp_lvl)
  );

  // word indexes of the mapped offsets
  localparam logic [6:0] IDX_TRIP     = 7'(`TTSC_OFS_TRIP >> 2);
  localparam logic [6:0] IDX_CAP      = 7'(`TTSC_OFS_CAP >> 2);
  localparam logic [6:0] IDX_IRQ_STAT = 7'(`TTSC_OFS_IRQ_STAT >> 2);
  localparam logic [6:0] IDX_IRQ_MASK = 7'(`TTSC_OFS_IRQ_MASK >> 2);
  localparam logic [6:0] IDX_EVCNT    = 7'(`TTSC_OFS_EVCNT >> 2);

  // address decode, low two address bits ignored
  assign word_idx     = rif.addr[`TTSC_ADDR_W-1:2];
  assign hit_trip     = (word_idx == IDX_TRIP);
  assign hit_cap      = (word_idx == IDX_CAP);
  assign hit_irq_stat = (word_idx == IDX_IRQ_STAT);
  assign hit_irq_mask = (word_idx == IDX_IRQ_MASK);
  assign hit_evcnt    = (word_idx == IDX_EVCNT);

  assign sel = hit_trip     ? sel_trip     :
               hit_cap      ? sel_cap      :
               hit_irq_stat ? sel_irq_stat :
               hit_irq_mask ? sel_irq_mask :
               hit_evcnt    ? sel_evcnt    :
                              sel_none;

  assign soft_trip_trigger = rif.wr & (sel == sel_trip) & rif.be[3]
                           & rif.wdata[`TTSC_TRIP_SW_BIT];

  // level edge, so a held overtemp gives one event
  assign overtemp_rise = overtemp_lvl & ~overtemp_lvl_d_ff;

  // trigger behaves as a real overtemp
  assign trip_event = overtemp_rise | soft_trip_trigger;

  // trip state only exists where supported
  assign enter_trip = trip_event & TRIP_STATE_SUPPORT;

  always_comb begin
    nxt_overtemp_sensed = overtemp_sensed_ff;
    if (overtemp_lvl || soft_trip_trigger) begin
      nxt_overtemp_sensed = 1'b1;
    end
  end

  always_comb begin
    nxt_trip_state = trip_state_ff;
    if (enter_trip) begin
      nxt_trip_state = 1'b1;
    end
  end

  // cold reset only; warm reset keeps the evidence of a trip
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overtemp_sensed_ff <= 1'b0;
      trip_state_ff      <= 1'b0;
    end else begin
      overtemp_sensed_ff <= nxt_overtemp_sensed;
      trip_state_ff      <= nxt_trip_state;
    end
  end

  // delay stage resets to the idle pin level, so no false edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overtemp_lvl_d_ff <= 1'b0;
      trip_event_ff     <= 1'b0;
    end else begin
      overtemp_lvl_d_ff <= overtemp_lvl;
      trip_event_ff     <= trip_event;
    end
  end

  // registered pulse, a clean edge for the shutdown sequencer
  assign trip_event_o = trip_event_ff;
  assign trip_state_o = trip_state_ff;

  // interrupt status, write one to clear, set wins
  assign stat_clr_wr = rif.wr & (sel == sel_irq_stat) & rif.be[0];
  assign mask_wr     = rif.wr & (sel == sel_irq_mask) & rif.be[0];
  assign irq_set[`TTSC_IRQ_OVERTEMP] = trip_event;
  assign irq_set[`TTSC_IRQ_TRIP]     = enter_trip & ~trip_state_ff;
  assign irq_clr = stat_clr_wr ? rif.wdata[`TTSC_IRQ_W-1:0]
                               : `TTSC_IRQ_RST;

  always_comb begin
    nxt_irq_mask = irq_mask_ff;
    if (mask_wr) begin
      nxt_irq_mask = rif.wdata[`TTSC_IRQ_W-1:0];
    end
  end

  // per-bit status: a set in the clear cycle wins
  for (genvar b = 0; b < `TTSC_IRQ_W; b++) begin : g_irq
    assign nxt_irq_stat[b] = irq_set[b] | (irq_stat_ff[b] & ~irq_clr[b]);
    assign irq_pend[b]     = nxt_irq_stat[b] & nxt_irq_mask[b];
  end

  // saturates instead of wrapping so a storm stays visible
  assign evcnt_full = &evcnt_ff;

  always_comb begin
    nxt_evcnt = evcnt_ff;
    if (trip_event && !evcnt_full) begin
      nxt_evcnt = evcnt_ff + {{(EVCNT_W-1){1'b0}}, 1'b1};
    end
  end

  // warm reset clears the software-facing interrupt state
  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      irq_stat_ff <= `TTSC_IRQ_RST;
      irq_mask_ff <= `TTSC_IRQ_RST;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || warm_rst_i) begin
      evcnt_ff <= '0;
      irq_ff   <= 1'b0;
    end else begin
      evcnt_ff <= nxt_evcnt;
      irq_ff   <= |irq_pend;
    end
  end

  assign irq_o = irq_ff;

  // trip status word
  always_comb begin
    trip_word = `TTSC_RST_WORD;
    trip_word[`TTSC_TRIP_SW_BIT] = 1'b0;
    trip_word[`TTSC_TRIP_DIODE_MSB:`TTSC_TRIP_DIODE_LSB] =
      DIODE_CORRECTION;
    trip_word[`TTSC_TRIP_SUP_BIT]   = TRIP_STATE_SUPPORT;
    trip_word[`TTSC_TRIP_SENSE_BIT] = overtemp_sensed_ff;
    trip_word[`TTSC_TRIP_STATE_BIT] = trip_state_ff;
  end

  // reserved core codes and rate codes 1 and 2 are mapped before software sees them; rate codes 4 to 6 pass unchanged
  assign core_field = core_code_legal(CORE_COUNT_CODE);
  assign rate_field = rate_code_legal(DRAM_RATE_CODE);

  // capabilities word, constant by construction
  always_comb begin
    cap_word = `TTSC_RST_WORD;
    cap_word[`TTSC_CAP_CORE_MSB:`TTSC_CAP_CORE_LSB] =
      core_field;
    cap_word[`TTSC_CAP_RETRY_BIT]  = LINK_RETRY;
    cap_word[`TTSC_CAP_THERM_BIT]  = THERMAL_CONTROL;
    cap_word[`TTSC_CAP_VIRT_BIT]   = VIRTUALIZATION;
    cap_word[`TTSC_CAP_MEMCTL_BIT] = MEMCTL_PRESENT;
    cap_word[`TTSC_CAP_RATE_MSB:`TTSC_CAP_RATE_LSB] =
      rate_field;
    cap_word[`TTSC_CAP_DUAL_BIT]   = DUAL_CHANNEL;
  end

  // no write path reaches capability bits
  always_comb begin
    read_word = `TTSC_RST_WORD;
    case (sel)
      sel_trip: begin
        read_word = trip_word;
      end
      sel_cap: begin
        read_word = cap_word;
      end
      sel_irq_stat: begin
        read_word[`TTSC_IRQ_W-1:0] = irq_stat_ff;
      end
      sel_irq_mask: begin
        read_word[`TTSC_IRQ_W-1:0] = irq_mask_ff;
      end
      sel_evcnt: begin
        read_word[EVCNT_W-1:0] = evcnt_ff;
      end
      default: begin
        read_word = `TTSC_RST_WORD;
      end
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= `TTSC_RST_WORD;
    end else if (rif.rd) begin
      rdata_ff <= read_word;
    end
  end

  assign rif.rdata = rdata_ff;

endmodule // ttsc_top

// ### ttsc_top_assertions.sv
// concurrent checks on the trip register bank ports
`timescale 1ns/10ps
`include "ttsc_cfg.svh"

module ttsc_top_chk (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [`TTSC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [`TTSC_DATA_W-1:0] wb_dat_i,
  input wire logic [`TTSC_DATA_W-1:0] wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic                    trip_event_o,
  input wire logic                    trip_state_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire logic req_new = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic rd_done = wb_ack_o && !wb_we_i;
  wire logic rd_trip = rd_done && wb_adr_i == `TTSC_OFS_TRIP;
  wire logic rd_cap  = rd_done && wb_adr_i == `TTSC_OFS_CAP;
  wire logic wr_trig = req_new && wb_we_i && wb_adr_i == `TTSC_OFS_TRIP
                       && wb_sel_i[3] && wb_dat_i[31];

  ack_latency_a: assert property (req_new |=> wb_ack_o)
    else $error("ack late after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  soft_trip_event_a: assert property (wr_trig |=> trip_event_o)
    else $error("trigger write gave no trip event");
  state_sticky_a: assert property (trip_state_o |=> trip_state_o)
    else $error("trip state dropped without reset");
  event_state_a: assert property (trip_event_o |-> trip_state_o)
    else $error("trip event without trip state");
  trig_reads_zero_a: assert property (
      rd_trip |-> (wb_dat_o & 32'hffff80d5) == 32'h0)
    else $error("trigger or reserved bit read nonzero");
  trip_const_a: assert property (
      rd_trip |-> wb_dat_o[14:8] == `TTSC_DIODE_DFLT && wb_dat_o[5])
    else $error("diode or support field wrong");
  sense_state_a: assert property (
      rd_trip |-> wb_dat_o[1] == $past(trip_state_o)
                  && (!wb_dat_o[1] || wb_dat_o[3]))
    else $error("state or sensed flag wrong");
  cap_word_a: assert property (rd_cap |-> wb_dat_o == 32'h00001f01)
    else $error("capability word wrong");

  cover property (wr_trig);
  cover property (rd_cap);
  cover property (trip_event_o && !wb_cyc_i);
endmodule // ttsc_top_chk

bind ttsc_top ttsc_top_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .trip_event_o, .trip_state_o);

// ### ttsc_top_tb.sv
// self-checking bench of the trip status register bank
`timescale 1ns/10ps

module ttsc_top_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, warm_rst_i = 1'b0;
  logic        overtemp_pin_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [8:0]  wb_adr_i = 9'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, trip_event_o, trip_state_o, irq_o;
  int          miscompares = 0, n_tests = 0, cycles = 0, n_events = 0;

  always #12.5 clk_i = ~clk_i;

  // trip pulses counted mid-cycle, where they have settled
  always @(negedge clk_i) begin
    if (trip_event_o === 1'b1) begin
      n_events++;
    end
  end

  ttsc_top dut (.clk_i, .rst_i, .warm_rst_i, .overtemp_pin_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .trip_event_o, .trip_state_o, .irq_o);

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // request held until ack is sampled, released on that edge
  task automatic wr(input logic [8:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h7;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask

  task automatic rc(input logic [8:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h6;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    ck(wb_dat_o, exp);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask

  task automatic wrap_up;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // a full run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(9'h0e4, 32'h00000b20);
    rc(9'h0e8, 32'h00001f01);
    rc(9'h0f0, 32'h00000000);
    rc(9'h104, 32'h00000000);
    $display("reset values done");
    wr(9'h0e8, 32'hffffffff, 4'hf);
    rc(9'h0e8, 32'h00001f01);
    wr(9'h0e4, 32'h7fffffff, 4'hf);
    wr(9'h0e4, 32'h80000000, 4'h7);
    rc(9'h0e4, 32'h00000b20);
    $display("read-only writes done");
    wr(9'h104, 32'h00000003, 4'h1);
    overtemp_pin_i <= 1'b1;
    // sync chain plus a margin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    ck({31'h0, trip_state_o}, 32'h1);
    ck({31'h0, irq_o}, 32'h1);
    ck(n_events, 32'h1);
    rc(9'h0e4, 32'h00000b2a);
    rc(9'h100, 32'h00000003);
    wr(9'h100, 32'h00000003, 4'h1);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    ck({31'h0, irq_o}, 32'h0);
    @(posedge clk_i);
    overtemp_pin_i <= 1'b0;
    warm_rst_i <= 1'b1;
    @(posedge clk_i);
    warm_rst_i <= 1'b0;
    rc(9'h0e4, 32'h00000b2a);
    rc(9'h104, 32'h00000000);
    $display("pin trip and warm reset done");
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(9'h0e4, 32'h00000b20);
    @(negedge clk_i);
    ck({31'h0, trip_state_o}, 32'h0);
    // diagnostic use of the trigger only
    wr(9'h0e4, 32'h80000000, 4'hf);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    ck({31'h0, trip_state_o}, 32'h1);
    ck(n_events, 32'h2);
    rc(9'h0e4, 32'h00000b2a);
    rc(9'h108, 32'h00000001);
    $display("soft trigger done");
    wrap_up();
  end
endmodule // ttsc_top_tb
